// [rtl/hpt_pkg.sv]
// Constants, types and reset state for the haptic playback trigger block
package hpt_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_MODE = 8'h01;
    localparam logic [7:0] ADDR_LIB = 8'h03;
    localparam logic [7:0] ADDR_SEQ0 = 8'h04;
    localparam logic [7:0] ADDR_SEQ7 = 8'h0B;
    localparam logic [7:0] ADDR_GO = 8'h0C;
    localparam logic [7:0] ADDR_ODT = 8'h0D;
    localparam logic [7:0] ADDR_SPT = 8'h0E;
    localparam logic [7:0] ADDR_SNT = 8'h0F;
    localparam logic [7:0] ADDR_BRK = 8'h10;
    // Field layout and reset values
    localparam int GO_BIT = 0;
    localparam int WAIT_BIT = 7;
    localparam logic [2:0] RST_LIB = 3'h1;
    localparam logic [2:0] RST_MODE = 3'h0;
    localparam logic [2:0] SLOT_LAST = 3'h7;
    // Operating mode encodings
    localparam logic [2:0] MODE_INT = 3'h0;
    localparam logic [2:0] MODE_EXT_EDGE = 3'h1;
    localparam logic [2:0] MODE_EXT_LEVEL = 3'h2;
    localparam logic [2:0] MODE_DIAG = 3'h6;
    localparam logic [2:0] MODE_CAL = 3'h7;
    // Timing
    localparam int CLK_KHZ = 10000;
    localparam int STEP_MS = 5;
    localparam int WAIT_MS = 10;
    localparam int STEP_CYC = STEP_MS * CLK_KHZ;
    localparam int WAIT_CYC = WAIT_MS * CLK_KHZ;
    localparam int TICK_W = 17;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_FETCH = 6'h02,
        ST_LOAD = 6'h04,
        ST_SEG = 6'h08,
        ST_WAIT = 6'h10,
        ST_PROC = 6'h20
    } hpt_state_e;

    // One library segment, answered combinationally by the waveform ROM
    typedef struct packed {
        logic signed [7:0] amp;
        logic [7:0] dur;
        logic signed [7:0] peak;
        logic last;
    } hpt_lib_s;

    typedef struct packed {
        hpt_state_e st;
        logic go;
        logic [2:0] mode;
        logic [2:0] lib_sel;
        logic [7:0][7:0] seq;
        logic [7:0] overdrive_time_adjust;
        logic [7:0] positive_sustain_adjust;
        logic [7:0] negative_sustain_adjust;
        logic [7:0] brt;
        logic [2:0] slot;
        logic [7:0] seg;
        logic [6:0] wave_id;
        logic [8:0] units;
        logic [TICK_W-1:0] tick;
        logic long_unit;
        logic sync1;
        logic sync2;
        logic pin_prev;
        logic signed [7:0] drive;
        logic cal_start;
        logic diag_start;
        logic [7:0] rdata;
    } hpt_state_s;

    localparam hpt_state_s STATE_RST = '{st: ST_IDLE, mode: RST_MODE, lib_sel: RST_LIB,
                                         default: '0};
endpackage : hpt_pkg

// [rtl/hpt_playback.sv]
// Playback trigger, sequencer and library segment time offsets
//
// Overview of operation
// [RULE_01] Trigger bit starts process chosen by mode
// [RULE_02] Internal mode: trigger plays the eight sequencer slots
// [RULE_03] Trigger reads one during playback, self-clears after
// [RULE_04] Host clearing trigger aborts remaining sequence
// [RULE_05] External trigger modes: pin sets/clears trigger
// [RULE_06] Calibration or diagnostic mode: trigger starts that
// [RULE_07] Maximum-amplitude segment is overdrive, offset adjusts it
// [RULE_08] Overdrive offset ignored in closed loop
// [RULE_09] Overdrive offset signed, 5 ms per step
// [RULE_10] Other positive amplitudes use positive sustain offset
// [RULE_11] Positive sustain offset signed, 5 ms per step
// [RULE_12] Other negative amplitudes use negative sustain offset
// [RULE_13] Negative sustain offset signed, 5 ms per step
// [RULE_14] Waveforms fetched from selected library
// [RULE_15] Slots in order, stop at zero or eighth
// [RULE_16] Top-bit slot idles seven bits times 10 ms
// [RULE_17] Negative total duration clamps to zero
`timescale 1ns/100ps
module hpt_playback #(
    parameter int STEP_CYC = hpt_pkg::STEP_CYC,
    parameter int WAIT_CYC = hpt_pkg::WAIT_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Register port
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Configuration and trigger pin
    input wire logic closed_loop,
    input wire logic ext_trig,
    // Waveform library
    output logic [2:0] lib_sel,
    output logic [6:0] lib_wave_id,
    output logic [7:0] lib_seg_idx,
    input wire hpt_pkg::hpt_lib_s lib_data,
    // Calibration and diagnostics
    output logic cal_start,
    output logic diag_start,
    input wire logic proc_done,
    // Drive
    output logic signed [7:0] drive_amp
);
    hpt_pkg::hpt_state_s q;
    hpt_pkg::hpt_state_s next_q;

    logic is_od;
    logic signed [7:0] off;
    logic signed [9:0] sum;
    logic [8:0] seg_units;
    logic [7:0] entry;
    logic playing;
    logic unit_done;
    logic slot_end;
    logic ext_set;
    logic [hpt_pkg::TICK_W-1:0] unit_last;

    assign entry = q.seq[q.slot];
    assign playing = (q.st == hpt_pkg::ST_FETCH) || (q.st == hpt_pkg::ST_LOAD)
                     || (q.st == hpt_pkg::ST_SEG) || (q.st == hpt_pkg::ST_WAIT);
    assign unit_last = q.long_unit ? hpt_pkg::TICK_W'(WAIT_CYC - 1)
                                   : hpt_pkg::TICK_W'(STEP_CYC - 1);
    assign unit_done = (q.tick == unit_last);

    // Segment classing: the peak is overdrive, else by sign; zero gets none
    always_comb begin
        is_od = (lib_data.amp == lib_data.peak) && (lib_data.amp != 8'sh00); // [RULE_07]
        if (is_od) begin
            off = closed_loop ? 8'sh00 : $signed(q.overdrive_time_adjust); // [RULE_08] [RULE_09]
        end else if (lib_data.amp > 8'sh00) begin
            off = $signed(q.positive_sustain_adjust); // [RULE_10] [RULE_11]
        end else if (lib_data.amp < 8'sh00) begin
            off = $signed(q.negative_sustain_adjust); // [RULE_12] [RULE_13]
        end else begin
            off = 8'sh00;
        end
        sum = $signed({2'b00, lib_data.dur}) + $signed({{2{off[7]}}, off});
        seg_units = sum[9] ? 9'h000 : sum[8:0]; // [RULE_17]
    end

    always_comb begin
        next_q = q;
        slot_end = 1'b0;
        ext_set = 1'b0;
        next_q.cal_start = 1'b0;
        next_q.diag_start = 1'b0;
        next_q.sync1 = ext_trig;
        next_q.sync2 = q.sync1;
        next_q.pin_prev = q.sync2;
        // External trigger pin drives the trigger bit
        if (q.mode == hpt_pkg::MODE_EXT_EDGE && q.sync2 && !q.pin_prev) begin
            ext_set = 1'b1; // [RULE_05]
        end
        if (q.mode == hpt_pkg::MODE_EXT_LEVEL) begin
            ext_set = q.sync2;
            next_q.go = q.sync2; // [RULE_05]
        end
        if (playing && !q.go) begin
            next_q.st = hpt_pkg::ST_IDLE; // [RULE_04]
            next_q.drive = 8'sh00;
        end else begin
            case (q.st)
                hpt_pkg::ST_IDLE: begin
                    next_q.drive = 8'sh00;
                    if (q.go) begin
                        case (q.mode) // [RULE_01]
                            hpt_pkg::MODE_INT, hpt_pkg::MODE_EXT_EDGE,
                            hpt_pkg::MODE_EXT_LEVEL: begin
                                next_q.slot = 3'h0; // [RULE_02]
                                next_q.st = hpt_pkg::ST_FETCH;
                            end
                            hpt_pkg::MODE_CAL: begin
                                next_q.cal_start = 1'b1; // [RULE_06]
                                next_q.st = hpt_pkg::ST_PROC;
                            end
                            hpt_pkg::MODE_DIAG: begin
                                next_q.diag_start = 1'b1; // [RULE_06]
                                next_q.st = hpt_pkg::ST_PROC;
                            end
                            default: next_q.st = hpt_pkg::ST_IDLE;
                        endcase
                    end
                end
                hpt_pkg::ST_FETCH: begin
                    next_q.tick = '0;
                    // Latched so the library address comes straight from a flop
                    next_q.wave_id = entry[6:0];
                    if (entry == 8'h00) begin
                        next_q.go = 1'b0; // [RULE_03] [RULE_15]
                        next_q.st = hpt_pkg::ST_IDLE;
                    end else if (entry[hpt_pkg::WAIT_BIT] && (entry[6:0] == 7'h00)) begin
                        slot_end = 1'b1; // [RULE_16]
                    end else if (entry[hpt_pkg::WAIT_BIT]) begin
                        next_q.units = {2'b00, entry[6:0]}; // [RULE_16]
                        next_q.long_unit = 1'b1;
                        next_q.drive = 8'sh00;
                        next_q.st = hpt_pkg::ST_WAIT;
                    end else begin
                        next_q.seg = 8'h00;
                        next_q.st = hpt_pkg::ST_LOAD;
                    end
                end
                hpt_pkg::ST_LOAD: begin
                    next_q.units = seg_units;
                    next_q.long_unit = 1'b0;
                    next_q.tick = '0;
                    if (seg_units != 9'h000) begin
                        next_q.drive = lib_data.amp;
                        next_q.st = hpt_pkg::ST_SEG;
                    end else if (lib_data.last) begin
                        slot_end = 1'b1;
                    end else begin
                        next_q.seg = q.seg + 8'h01;
                    end
                end
                hpt_pkg::ST_SEG, hpt_pkg::ST_WAIT: begin
                    next_q.tick = q.tick + hpt_pkg::TICK_W'(1);
                    if (unit_done) begin
                        next_q.tick = '0;
                        next_q.units = q.units - 9'h001;
                        if (q.units <= 9'h001) begin
                            if (q.st == hpt_pkg::ST_WAIT || lib_data.last) begin
                                slot_end = 1'b1;
                            end else begin
                                next_q.seg = q.seg + 8'h01;
                                // Drive drops in the load cycle so a segment lasts its units only
                                next_q.drive = 8'sh00;
                                next_q.st = hpt_pkg::ST_LOAD;
                            end
                        end
                    end
                end
                hpt_pkg::ST_PROC: begin
                    if (proc_done) begin
                        next_q.go = 1'b0; // [RULE_03]
                        next_q.st = hpt_pkg::ST_IDLE;
                    end
                end
                default: next_q.st = hpt_pkg::ST_IDLE;
            endcase
        end
        // Waits hold no drive; a zero-wait slot falls straight through
        if (slot_end) begin
            next_q.drive = 8'sh00;
            if (q.slot == hpt_pkg::SLOT_LAST) begin
                next_q.go = 1'b0; // [RULE_15] [RULE_03]
                next_q.st = hpt_pkg::ST_IDLE;
            end else begin
                next_q.slot = q.slot + 3'h1; // [RULE_15]
                next_q.st = hpt_pkg::ST_FETCH;
            end
        end
        if (ext_set) begin
            next_q.go = 1'b1;
        end
        // Host write comes last so a set beats a same-cycle clear
        if (reg_wr) begin
            case (reg_addr)
                hpt_pkg::ADDR_MODE: next_q.mode = reg_wdata[2:0];
                hpt_pkg::ADDR_LIB: next_q.lib_sel = reg_wdata[2:0];
                hpt_pkg::ADDR_GO: next_q.go = reg_wdata[hpt_pkg::GO_BIT] | ext_set; // [RULE_04]
                hpt_pkg::ADDR_ODT: next_q.overdrive_time_adjust = reg_wdata;
                hpt_pkg::ADDR_SPT: next_q.positive_sustain_adjust = reg_wdata;
                hpt_pkg::ADDR_SNT: next_q.negative_sustain_adjust = reg_wdata;
                hpt_pkg::ADDR_BRK: next_q.brt = reg_wdata;
                default: begin
                    if (reg_addr >= hpt_pkg::ADDR_SEQ0 && reg_addr <= hpt_pkg::ADDR_SEQ7) begin
                        next_q.seq[3'(reg_addr - hpt_pkg::ADDR_SEQ0)] = reg_wdata;
                    end
                end
            endcase
        end
        case (reg_addr)
            hpt_pkg::ADDR_MODE: next_q.rdata = {5'h00, q.mode};
            hpt_pkg::ADDR_LIB: next_q.rdata = {5'h00, q.lib_sel};
            hpt_pkg::ADDR_GO: next_q.rdata = {7'h00, q.go}; // [RULE_03]
            hpt_pkg::ADDR_ODT: next_q.rdata = q.overdrive_time_adjust;
            hpt_pkg::ADDR_SPT: next_q.rdata = q.positive_sustain_adjust;
            hpt_pkg::ADDR_SNT: next_q.rdata = q.negative_sustain_adjust;
            hpt_pkg::ADDR_BRK: next_q.rdata = q.brt;
            default: begin
                if (reg_addr >= hpt_pkg::ADDR_SEQ0 && reg_addr <= hpt_pkg::ADDR_SEQ7) begin
                    next_q.rdata = q.seq[3'(reg_addr - hpt_pkg::ADDR_SEQ0)];
                end else begin
                    next_q.rdata = 8'h00;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= hpt_pkg::STATE_RST;
        end else begin
            q <= next_q;
        end
    end

    assign reg_rdata = q.rdata;
    assign lib_sel = q.lib_sel; // [RULE_14]
    assign lib_wave_id = q.wave_id;
    assign lib_seg_idx = q.seg;
    assign cal_start = q.cal_start;
    assign diag_start = q.diag_start;
    assign drive_amp = q.drive;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence s_play_cleared;
        playing && !q.go;
    endsequence

    a_play_start: assert property ((q.st == hpt_pkg::ST_IDLE) && q.go && (q.mode == hpt_pkg::MODE_INT)
        |=> (q.st == hpt_pkg::ST_FETCH) && (q.slot == 3'h0)) // [RULE_02]
        else $error("sequence did not start from slot zero");
    a_abort_idle: assert property (s_play_cleared |=> (q.st == hpt_pkg::ST_IDLE)
        && (drive_amp == 8'sh00)) // [RULE_04]
        else $error("cleared trigger did not abort playback");
    a_zero_stop: assert property ((q.st == hpt_pkg::ST_FETCH) && q.go && (entry == 8'h00)
        && !reg_wr && !ext_set |=> !q.go
        ##1 ((reg_rdata[0] == 1'b0) || ($past(reg_addr) != hpt_pkg::ADDR_GO))) // [RULE_15]
        else $error("zero slot did not end sequence");
    a_wait_units: assert property ((q.st == hpt_pkg::ST_FETCH) && q.go && entry[7]
        && (entry[6:0] != 7'h00) |=> (q.st == hpt_pkg::ST_WAIT)
        && (q.units == $past(9'(entry[6:0]))) && q.long_unit) // [RULE_16]
        else $error("wait slot loaded wrong count");
    a_od_closed: assert property (closed_loop && is_od |-> seg_units == 9'(lib_data.dur)) // [RULE_08]
        else $error("overdrive offset applied in closed loop");
    a_od_open: assert property (!closed_loop && is_od && !sum[9]
        |-> seg_units == 9'($signed({2'b00, lib_data.dur}) + $signed({{2{q.overdrive_time_adjust[7]}}, q.overdrive_time_adjust})))
        // [RULE_09]
        else $error("overdrive offset wrong");
    a_sus_neg: assert property (!is_od && (lib_data.amp < 8'sh00)
        |-> off == $signed(q.negative_sustain_adjust)) // [RULE_12]
        else $error("negative sustain offset not used");
    a_clamp_zero: assert property (sum[9] |-> seg_units == 9'h000) // [RULE_17]
        else $error("negative duration wrapped");
    a_cal_start: assert property ((q.st == hpt_pkg::ST_IDLE) && q.go && (q.mode == hpt_pkg::MODE_CAL)
        |=> cal_start ##1 !cal_start) // [RULE_06]
        else $error("calibration not started");
    a_last_slot: assert property (slot_end && (q.slot == hpt_pkg::SLOT_LAST) && !reg_wr && !ext_set
        |=> !q.go && (q.st == hpt_pkg::ST_IDLE)) // [RULE_15]
        else $error("sequence ran past eighth slot");
endmodule : hpt_playback

// [test/hpt_lib_model.sv]
// Waveform library model: answers segment lookups combinationally
`timescale 1ns/100ps
module hpt_lib_model (
    // Lookup
    input wire logic [2:0] lib_sel,
    input wire logic [6:0] lib_wave_id,
    input wire logic [7:0] lib_seg_idx,
    // Answer
    output hpt_pkg::hpt_lib_s lib_data
);
    // Wave one: overdrive, positive sustain, negative sustain
    localparam hpt_pkg::hpt_lib_s WAVE_ONE [3] = '{
        '{8'h7F, 8'h02, 8'h7F, 1'b0},
        '{8'h40, 8'h03, 8'h7F, 1'b0},
        '{8'hC0, 8'h01, 8'h7F, 1'b1}};
    logic [7:0] amp_two;

    // Library two plays wave two louder, so a wrong library shows
    assign amp_two = (lib_sel == 3'h2) ? 8'h30 : 8'h20;
    always_comb begin
        lib_data = '{8'h00, 8'h00, 8'h00, 1'b1};
        if (lib_wave_id == 7'h01 && lib_seg_idx < 8'h03) begin
            lib_data = WAVE_ONE[lib_seg_idx[1:0]];
        end else if (lib_wave_id == 7'h02 && lib_seg_idx == 8'h00) begin
            lib_data = '{amp_two, 8'h08, amp_two, 1'b1};
        end else if (lib_wave_id == 7'h03 && lib_seg_idx == 8'h00) begin
            lib_data = '{8'h10, 8'h08, 8'h10, 1'b1};
        end
    end
endmodule : hpt_lib_model

// [test/tb_top.sv]
// Self-checking bench for the playback trigger block
`timescale 1ns/100ps
module tb_top;
    // Short step and wait counts keep the run brief
    localparam int STEP = 4;
    localparam int WAITC = 8;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic closed_loop = 1'b0;
    logic ext_trig = 1'b0;
    logic proc_done = 1'b0;
    logic [2:0] lib_sel;
    logic [6:0] lib_wave_id;
    logic [7:0] lib_seg_idx;
    hpt_pkg::hpt_lib_s lib_data;
    logic cal_start;
    logic diag_start;
    logic signed [7:0] drive_amp;
    int bad_count = 0;
    int check_count = 0;

    always #50 sys_clk = ~sys_clk;

    hpt_playback #(.STEP_CYC(STEP), .WAIT_CYC(WAITC)) u_hpt_playback (
        .sys_clk(sys_clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .closed_loop(closed_loop),
        .ext_trig(ext_trig), .lib_sel(lib_sel), .lib_wave_id(lib_wave_id),
        .lib_seg_idx(lib_seg_idx), .lib_data(lib_data), .cal_start(cal_start),
        .diag_start(diag_start), .proc_done(proc_done), .drive_amp(drive_amp));
    hpt_lib_model u_hpt_lib_model (.lib_sel(lib_sel), .lib_wave_id(lib_wave_id),
        .lib_seg_idx(lib_seg_idx), .lib_data(lib_data));

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    // Writes n bytes, lowest byte to the lowest address
    task automatic wrs(input logic [7:0] a, input logic [63:0] d, input int n);
        for (int i = 0; i < n; i++) begin
            wr(a + 8'(i), d[8*i +: 8]);
        end
    endtask : wrs

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string msg);
        @(posedge sys_clk);
        reg_addr <= a;
        tick(2);
        chk(reg_rdata, exp, msg);
    endtask : rd

    task automatic wait_amp(input logic [7:0] amp, input int wmin, input int wmax);
        int w;
        w = 0;
        while (drive_amp !== amp) begin
            if (w >= wmax) begin
                chk(drive_amp, amp, "segment never started");
                give_verdict();
            end
            tick(1);
            w++;
        end
        if (w < wmin) chk(8'(w), 8'(wmin), "segment started early");
    endtask : wait_amp

    // Measures one segment; trigger bit must read one all through
    task automatic seg(input logic [7:0] amp, input int units, input int wmin, input int wmax);
        int n;
        n = 0;
        wait_amp(amp, wmin, wmax);
        while (drive_amp === amp && n <= units * STEP) begin
            chk(reg_rdata, 8'h01, "trigger low in playback");
            tick(1);
            n++;
        end
        chk(8'(n), 8'(units * STEP), "segment length");
    endtask : seg

    task automatic done_wait();
        int w;
        w = 0;
        while (reg_rdata !== 8'h00 && w < 20) begin
            tick(1);
            w++;
        end
        chk(reg_rdata, 8'h00, "trigger not self-cleared");
        chk(drive_amp, 8'h00, "drive not released");
        if (reg_rdata !== 8'h00) give_verdict();
    endtask : done_wait

    task automatic t_regs();
        rd(8'h0C, 8'h00, "trigger reset");
        rd(8'h0D, 8'h00, "overdrive reset");
        rd(8'h0E, 8'h00, "pos sustain reset");
        rd(8'h0F, 8'h00, "neg sustain reset");
        rd(8'h03, 8'h01, "library reset");
        for (int i = 0; i < 4; i++) begin
            wr(8'h0D + 8'(i), 8'hA5 + 8'(i));
            rd(8'h0D + 8'(i), 8'hA5 + 8'(i), "offset readback");
        end
        wr(8'h20, 8'h5A);
        rd(8'h20, 8'h00, "unmapped read");
        wr(8'h0C, 8'hFE);
        rd(8'h0C, 8'h00, "reserved trigger bits");
    endtask : t_regs

    task automatic t_open();
        wrs(8'h04, 64'h020001, 3);
        wrs(8'h0D, 64'h02FF01, 3);
        wr(8'h0C, 8'h01);
        seg(8'h7F, 3, 0, 10);
        seg(8'h40, 2, 0, 5);
        seg(8'hC0, 3, 0, 5);
        done_wait();
    endtask : t_open

    task automatic t_closed();
        @(posedge sys_clk);
        closed_loop <= 1'b1;
        wrs(8'h0E, 64'h00FB, 2);
        wr(8'h0C, 8'h01);
        seg(8'h7F, 2, 0, 10);
        seg(8'hC0, 1, 0, 6);
        done_wait();
    endtask : t_closed

    task automatic t_slots();
        wr(8'h03, 8'h02);
        wrs(8'h04, 64'h0203020302038102, 8);
        wr(8'h0C, 8'h01);
        seg(8'h30, 8, 0, 10);
        seg(8'h10, 8, WAITC, WAITC + 10);
        for (int i = 0; i < 5; i++) begin
            seg((i % 2) ? 8'h10 : 8'h30, 8, 0, 6);
        end
        done_wait();
    endtask : t_slots

    task automatic t_abort();
        wrs(8'h04, 64'h8101, 2);
        wr(8'h0C, 8'h01);
        wait_amp(8'h7F, 0, 10);
        wr(8'h0C, 8'h00);
        tick(2);
        for (int i = 0; i < 40; i++) begin
            chk(reg_rdata | drive_amp, 8'h00, "sequence not aborted");
            tick(1);
        end
        wr(8'h05, 8'h00);
    endtask : t_abort

    task automatic t_ext();
        wr(8'h01, 8'h02);
        rd(8'h0C, 8'h00, "level mode idle");
        @(posedge sys_clk);
        ext_trig <= 1'b1;
        wait_amp(8'h7F, 0, 12);
        chk(reg_rdata, 8'h01, "pin did not set trigger");
        @(posedge sys_clk);
        ext_trig <= 1'b0;
        tick(6);
        chk(reg_rdata | drive_amp, 8'h00, "pin low did not abort");
        wr(8'h01, 8'h01);
        rd(8'h0C, 8'h00, "edge mode idle");
        @(posedge sys_clk);
        ext_trig <= 1'b1;
        @(posedge sys_clk);
        ext_trig <= 1'b0;
        seg(8'h7F, 2, 0, 14);
        seg(8'hC0, 1, 0, 6);
        done_wait();
    endtask : t_ext

    task automatic t_proc();
        int w;
        for (int i = 0; i < 2; i++) begin
            wr(8'h01, i ? 8'h06 : 8'h07);
            wr(8'h0C, 8'h01);
            w = 0;
            while ((cal_start | diag_start) !== 1'b1 && w < 6) begin
                tick(1);
                w++;
            end
            chk({6'h00, cal_start, diag_start}, i ? 8'h01 : 8'h02, "process start");
            if ((cal_start | diag_start) !== 1'b1) give_verdict();
            tick(1);
            chk(drive_amp | {6'h00, cal_start, diag_start}, 8'h00, "start not a pulse");
            chk(reg_rdata, 8'h01, "trigger low in process");
            @(posedge sys_clk);
            proc_done <= 1'b1;
            @(posedge sys_clk);
            proc_done <= 1'b0;
            done_wait();
        end
    endtask : t_proc

    initial begin
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_regs();
        t_open();
        t_closed();
        t_slots();
        t_abort();
        t_ext();
        t_proc();
        give_verdict();
    end
endmodule : tb_top
